// [shared/vps_map.vh]
// Purpose: Register map, field positions, reset values and timing counts of the path sequencer
// Assumes: Classic Wishbone, byte addresses, 32-bit words
// Notes: Angles in 1/16 degree, tangent scale in 16.16 counts per degree
`ifndef VPS_MAP_VH
`define VPS_MAP_VH

`define VPS_REG_CMD 8'h00
`define VPS_REG_PLANE_SELECT 8'h04
`define VPS_REG_PLANE_AXES 8'h08
`define VPS_REG_TAN_SCALE 8'h0c
`define VPS_REG_TAN_OFFSET 8'h10
`define VPS_REG_SEG_DX 8'h14
`define VPS_REG_SEG_DY 8'h18
`define VPS_REG_SEG_LEN 8'h1c
`define VPS_REG_SEG_ANGLE 8'h20
`define VPS_REG_PATH_SPEED 8'h28
`define VPS_REG_PATH_ACCEL 8'h2c
`define VPS_REG_PATH_DECEL 8'h30
`define VPS_REG_SPEED_RATIO 8'h34
`define VPS_REG_SCURVE 8'h38
`define VPS_REG_PATH_DIST 8'h3c
`define VPS_REG_AFTER_DIST 8'h40
`define VPS_REG_WAIT_DONE 8'h44
`define VPS_REG_FREE_SLOTS 8'h48
`define VPS_REG_SEG_COUNT 8'h4c
`define VPS_REG_LEN_TOTAL 8'h50
`define VPS_REG_VERTEX_A 8'h54
`define VPS_REG_VERTEX_B 8'h58
`define VPS_REG_TAN_INIT 8'h5c

`define VPS_CMD_BEGIN 0
`define VPS_CMD_CLEAR 1
`define VPS_CMD_END 2
`define VPS_CMD_PUSH 3
`define VPS_CMD_SYS 8
`define VPS_CMD_ARC 9
`define VPS_AXES_TAN_EN 11

`define VPS_RST_SPEED 32'h00006400
`define VPS_RST_ACCEL 32'h00040000
`define VPS_RST_RATIO 17'h02710
`define VPS_RST_SCURVE 9'h100
`define VPS_RST_AXES 12'h010

`define VPS_SEG_MAX 10'h1ff
`define VPS_ANG_QUARTER 16'h05a0
`define VPS_VMIN 32'h00000040
`define VPS_RATIO_RECIP 20'h68db9
`define VPS_CLK_MHZ 125
`define VPS_TICK_NS 976563
`define VPS_TICK_CYCLES ((`VPS_TICK_NS * `VPS_CLK_MHZ) / 1000)

`endif

// [hdl/vps_seg_fifo.v]
// Purpose: Segment queue, up to 511 entries, head visible without a pop
// Assumes: Single clock, synchronous reset
// Notes: Full at 511 so the free count spans 0..511
`timescale 1ns/10ps
`include "vps_map.vh"
module vps_seg_fifo (
	input wire clk_i,
	input wire rst_i,
	input wire flush_i,
	input wire push_i,
	input wire [128:0] din_i,
	input wire pop_i,
	output wire [128:0] dout_o,
	output wire empty_o,
	output wire full_o,
	output wire [9:0] count_o
);
	reg [128:0] mem [0:511];
	reg [8:0] wr_q;
	reg [8:0] rd_q;
	reg [9:0] cnt_q;
	wire do_push = push_i && !full_o;
	wire do_pop = pop_i && !empty_o;
	assign dout_o = mem[rd_q];
	assign empty_o = (cnt_q == 10'h000);
	assign full_o = (cnt_q == `VPS_SEG_MAX);
	assign count_o = cnt_q;
	always @(posedge clk_i) begin
		if (do_push)
			mem[wr_q] <= din_i;
	end
	always @(posedge clk_i) begin
		if (rst_i || flush_i) begin
			wr_q <= 9'h000;
			rd_q <= 9'h000;
			cnt_q <= 10'h000;
		end else begin
			if (do_push)
				wr_q <= wr_q + 9'h001;
			if (do_pop)
				rd_q <= rd_q + 9'h001;
			if (do_push && !do_pop)
				cnt_q <= cnt_q + 10'h001;
			else if (do_pop && !do_push)
				cnt_q <= cnt_q - 10'h001;
		end
	end
endmodule

// [hdl/vps_frac_div.v]
// Purpose: Serial divider giving a 16-bit fraction num/den
// Assumes: num below den, den nonzero
// Notes: 16 cycles from start to done
`timescale 1ns/10ps
module vps_frac_div (
	input wire clk_i,
	input wire rst_i,
	input wire start_i,
	input wire [47:0] num_i,
	input wire [47:0] den_i,
	output reg done_o,
	output reg [15:0] frac_o
);
	reg [48:0] rem_q;
	reg [47:0] den_q;
	reg [4:0] cnt_q;
	wire [48:0] shifted = {rem_q[47:0], 1'b0};
	wire take = (shifted >= {1'b0, den_q});
	always @(posedge clk_i) begin
		if (rst_i) begin
			rem_q <= 49'h0;
			den_q <= 48'h0;
			cnt_q <= 5'h00;
			done_o <= 1'b0;
			frac_o <= 16'h0000;
		end else begin
			done_o <= 1'b0;
			if (start_i) begin
				rem_q <= {1'b0, num_i};
				den_q <= den_i;
				cnt_q <= 5'h10;
			end else if (cnt_q != 5'h00) begin
				rem_q <= take ? shifted - {1'b0, den_q} : shifted;
				frac_o <= {frac_o[14:0], take};
				cnt_q <= cnt_q - 5'h01;
				if (cnt_q == 5'h01)
					done_o <= 1'b1;
			end
		end
	end
endmodule

// [hdl/vps_path_seq.v]
// Purpose: Two-system coordinated line/arc path sequencer with tangent axis following
// Assumes: Software supplies segment end deltas, lengths and headings already computed
// Notes: Axis outputs are command positions; the drive loop is outside this block
// Contract
// - Next command waits until path distance reaches the requested trip distance.
// - Exactly one tangent axis is chosen together with the two plane axes.
// - Tangent parameter given as none disables tangent following.
// - Tangent scale in counts per degree plus offset at zero degrees.
// - Initial tangent position of the queued path is readable.
// - Arc is radius, start angle, signed travel angle; positive means counter-clockwise.
// - Begin command starts the queued sequence of the named system.
// - Clear command discards the queued segments of the named system.
// - Wait command stalls program until the motion sequence completes.
// - Free slot count reads zero when full, 511 when empty.
// - Segment counter gives running segment index, first one zero.
// - Total vector length of the queued sequence is readable.
// - Distance travelled along the running path is readable.
// - Last passed junction coordinate per axis; start point during first segment.
// - Plane select picks which system receives later vector commands.
// - Per-system speed, acceleration, deceleration and ratio applied along path.
// - Per-system S-curve smoothing constant shapes the path profile.
// - At most 511 segments per sequence; an end marker closes it.
// - Queue running dry without end marker stops motion at once.
//
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/10ps
`include "vps_map.vh"
module vps_path_seq #(
	parameter TICK_CYC = `VPS_TICK_CYCLES
) (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output wire wb_ack_o,
	output wire [2:0] axis_m_o,
	output wire [2:0] axis_n_o,
	output wire [2:0] axis_p_o,
	output wire tangent_en_o,
	output reg [31:0] pos_a_o,
	output reg [31:0] pos_b_o,
	output reg [31:0] tangent_pos_o,
	output wire moving_o,
	output wire run_sys_o
);
	localparam ST_IDLE = 2'd0;
	localparam ST_RUN = 2'd1;
	localparam ST_CHK = 2'd2;
	localparam ST_DIV = 2'd3;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] sel;
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1)
				merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	// Heading in 1/16 degree: offset plus scale times angle, 16.16 scale
	function [31:0] tan_of;
		input [31:0] offs;
		input [31:0] scale;
		input [15:0] head;
		reg [47:0] p;
		begin
			p = $signed(scale) * $signed(head);
			tan_of = offs + {{4{p[47]}}, p[47:20]};
		end
	endfunction

	reg [1:0] st_q;
	reg plane_sel_q;
	reg [11:0] axes_q;
	reg [31:0] tscale_q, toffs_q;
	reg [31:0] sdx_q, sdy_q, slen_q, sang_q;
	reg [31:0] spd_q [0:1];
	reg [31:0] acc_q [0:1];
	reg [31:0] dec_q [0:1];
	reg [16:0] ratio_q [0:1];
	reg [8:0] itc_q [0:1];
	reg [31:0] trip_q;
	reg owner_q, run_sys_q, end_seen_q, dry_stop_q;
	reg [31:0] total_q;
	reg [15:0] head0_q;
	reg [31:0] vert_a_q, vert_b_q;
	reg [31:0] dist_done_q;
	reg [9:0] seg_cnt_q;
	reg cur_arc_q;
	reg [31:0] cur_dx_q, cur_dy_q, cur_len_q, cur_ang_q;
	reg [47:0] seg_pos_q;
	reg [47:0] v_fx_q;
	reg [32:0] a_eff_q;
	reg [15:0] frac_q;
	reg [16:0] tick_cnt_q;
	reg ack_q;

	wire bus_req = wb_cyc_i && wb_stb_i && !ack_q;
	wire wr = bus_req && wb_we_i;
	wire running = (st_q != ST_IDLE);
	wire tick = (tick_cnt_q == 17'h00000);
	wire [128:0] fifo_dout;
	wire fifo_empty, fifo_full;
	wire [9:0] fifo_count;
	wire div_done;
	wire [15:0] div_frac;
	wire cmd_wr = wr && (wb_adr_i == `VPS_REG_CMD);
	wire cmd_sys = wb_dat_i[`VPS_CMD_SYS];
	wire push_ok = cmd_wr && wb_dat_i[`VPS_CMD_PUSH] && !fifo_full && !end_seen_q &&
		(fifo_empty || owner_q == plane_sel_q);
	wire clr_ok = cmd_wr && wb_dat_i[`VPS_CMD_CLEAR] && !running && owner_q == cmd_sys;
	wire beg_ok = cmd_wr && wb_dat_i[`VPS_CMD_BEGIN] && !running && !fifo_empty && owner_q == cmd_sys;
	wire [47:0] len_fx = {6'h00, cur_len_q, 10'h000};
	wire last_seg = fifo_empty && end_seen_q;
	wire [31:0] v_now = v_fx_q[41:10];
	wire [68:0] tgt_full = spd_q[run_sys_q] * ratio_q[run_sys_q] * `VPS_RATIO_RECIP;
	wire [31:0] tgt = tgt_full[63:32];
	wire [47:0] rem_fx = len_fx - seg_pos_q;
	wire [95:0] stop_lhs = rem_fx * {dec_q[run_sys_q], 1'b0};
	wire [63:0] v_sq = v_now * v_now;
	wire [73:0] stop_rhs = {v_sq, 10'h000};
	wire decel = last_seg && (stop_lhs[95:0] <= {22'h0, stop_rhs});
	wire [32:0] a_goal = (decel || v_now > tgt) ? ({1'b1, ~dec_q[run_sys_q]} + 33'h1) :
		(v_now < tgt ? {1'b0, acc_q[run_sys_q]} : 33'h0);
	// Signed step toward the goal; sign kept so braking shifts in ones
	wire signed [43:0] a_step = ($signed({a_goal[32], a_goal}) - $signed({a_eff_q[32], a_eff_q})) *
		$signed({1'b0, itc_q[run_sys_q]});
	wire [31:0] path_dist = dist_done_q + seg_pos_q[41:10];
	wire [15:0] head_now = cur_arc_q ?
		(cur_ang_q[15:0] + ($signed(cur_ang_q[31:16]) < 0 ? -`VPS_ANG_QUARTER : `VPS_ANG_QUARTER) +
		((frac_mul(cur_ang_q[31:16], frac_q)))) : cur_ang_q[15:0];
	wire [15:0] push_head = wb_dat_i[`VPS_CMD_ARC] ?
		(sang_q[15:0] + ($signed(sang_q[31:16]) < 0 ? -`VPS_ANG_QUARTER : `VPS_ANG_QUARTER)) : sang_q[15:0];
	wire trip_ready = !running || path_dist >= trip_q;
	wire wait_ready = !running;
	wire stall = !wb_we_i && ((wb_adr_i == `VPS_REG_AFTER_DIST && !trip_ready) ||
		(wb_adr_i == `VPS_REG_WAIT_DONE && !wait_ready));

	// Scales a signed 16-bit quantity by a 0..1 fraction
	function [15:0] frac_mul;
		input [15:0] val;
		input [15:0] fr;
		reg [32:0] p;
		begin
			p = $signed(val) * $signed({1'b0, fr});
			frac_mul = p[31:16];
		end
	endfunction

	function [31:0] frac_mul32;
		input [31:0] val;
		input [15:0] fr;
		reg [48:0] p;
		begin
			p = $signed(val) * $signed({1'b0, fr});
			frac_mul32 = p[47:16];
		end
	endfunction

	wire [31:0] axes_wr = merge({20'h0, axes_q}, wb_dat_i, wb_sel_i);

	assign wb_ack_o = ack_q;
	assign axis_m_o = axes_q[2:0];
	assign axis_n_o = axes_q[6:4];
	assign axis_p_o = axes_q[10:8];
	assign tangent_en_o = axes_q[`VPS_AXES_TAN_EN];
	assign moving_o = running;
	assign run_sys_o = run_sys_q;

	wire div_start = (st_q == ST_CHK) && seg_pos_q < len_fx;
	wire seg_end = (st_q == ST_CHK) && seg_pos_q >= len_fx;
	wire pop = beg_ok || (seg_end && !fifo_empty);

	vps_seg_fifo u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.flush_i(clr_ok),
		.push_i(push_ok),
		.din_i({wb_dat_i[`VPS_CMD_ARC], sdx_q, sdy_q, slen_q, sang_q}),
		.pop_i(pop),
		.dout_o(fifo_dout),
		.empty_o(fifo_empty),
		.full_o(fifo_full),
		.count_o(fifo_count)
	);

	vps_frac_div u_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(div_start),
		.num_i(seg_pos_q),
		.den_i(len_fx),
		.done_o(div_done),
		.frac_o(div_frac)
	);

	// Bus: ack one cycle after the request, later while a trip or wait read stalls
	always @(posedge clk_i) begin
		if (rst_i)
			ack_q <= 1'b0;
		else
			ack_q <= bus_req && !stall;
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0;
		end else if (bus_req && !wb_we_i) begin
			case (wb_adr_i)
				`VPS_REG_CMD: wb_dat_o <= {26'h0, plane_sel_q, dry_stop_q, end_seen_q, owner_q, run_sys_q, running};
				`VPS_REG_PLANE_SELECT: wb_dat_o <= {31'h0, plane_sel_q};
				`VPS_REG_PLANE_AXES: wb_dat_o <= {20'h0, axes_q};
				`VPS_REG_TAN_SCALE: wb_dat_o <= tscale_q;
				`VPS_REG_TAN_OFFSET: wb_dat_o <= toffs_q;
				`VPS_REG_SEG_DX: wb_dat_o <= sdx_q;
				`VPS_REG_SEG_DY: wb_dat_o <= sdy_q;
				`VPS_REG_SEG_LEN: wb_dat_o <= slen_q;
				`VPS_REG_SEG_ANGLE: wb_dat_o <= sang_q;
				`VPS_REG_PATH_SPEED: wb_dat_o <= spd_q[plane_sel_q];
				`VPS_REG_PATH_ACCEL: wb_dat_o <= acc_q[plane_sel_q];
				`VPS_REG_PATH_DECEL: wb_dat_o <= dec_q[plane_sel_q];
				`VPS_REG_SPEED_RATIO: wb_dat_o <= {15'h0, ratio_q[plane_sel_q]};
				`VPS_REG_SCURVE: wb_dat_o <= {23'h0, itc_q[plane_sel_q]};
				`VPS_REG_PATH_DIST, `VPS_REG_AFTER_DIST: wb_dat_o <= path_dist;
				`VPS_REG_FREE_SLOTS: wb_dat_o <= {22'h0, `VPS_SEG_MAX - fifo_count};
				`VPS_REG_SEG_COUNT: wb_dat_o <= {22'h0, seg_cnt_q};
				`VPS_REG_LEN_TOTAL: wb_dat_o <= total_q;
				`VPS_REG_VERTEX_A: wb_dat_o <= vert_a_q;
				`VPS_REG_VERTEX_B: wb_dat_o <= vert_b_q;
				`VPS_REG_TAN_INIT: wb_dat_o <= tan_of(toffs_q, tscale_q, head0_q);
				default: wb_dat_o <= 32'h0;
			endcase
		end
	end

	// Register writes; speed, accel, decel, ratio and S-curve go into the system picked by plane select
	always @(posedge clk_i) begin
		if (rst_i) begin
			plane_sel_q <= 1'b0;
			axes_q <= `VPS_RST_AXES;
			tscale_q <= 32'h0;
			toffs_q <= 32'h0;
			sdx_q <= 32'h0;
			sdy_q <= 32'h0;
			slen_q <= 32'h0;
			sang_q <= 32'h0;
			trip_q <= 32'h0;
			spd_q[0] <= `VPS_RST_SPEED;
			spd_q[1] <= `VPS_RST_SPEED;
			acc_q[0] <= `VPS_RST_ACCEL;
			acc_q[1] <= `VPS_RST_ACCEL;
			dec_q[0] <= `VPS_RST_ACCEL;
			dec_q[1] <= `VPS_RST_ACCEL;
			ratio_q[0] <= `VPS_RST_RATIO;
			ratio_q[1] <= `VPS_RST_RATIO;
			itc_q[0] <= `VPS_RST_SCURVE;
			itc_q[1] <= `VPS_RST_SCURVE;
		end else if (wr) begin
			case (wb_adr_i)
				`VPS_REG_PLANE_SELECT: if (wb_sel_i[0]) plane_sel_q <= wb_dat_i[0];
				`VPS_REG_PLANE_AXES: axes_q <= axes_wr[11:0];
				`VPS_REG_TAN_SCALE: tscale_q <= merge(tscale_q, wb_dat_i, wb_sel_i);
				`VPS_REG_TAN_OFFSET: toffs_q <= merge(toffs_q, wb_dat_i, wb_sel_i);
				`VPS_REG_SEG_DX: sdx_q <= merge(sdx_q, wb_dat_i, wb_sel_i);
				`VPS_REG_SEG_DY: sdy_q <= merge(sdy_q, wb_dat_i, wb_sel_i);
				`VPS_REG_SEG_LEN: slen_q <= merge(slen_q, wb_dat_i, wb_sel_i);
				`VPS_REG_SEG_ANGLE: sang_q <= merge(sang_q, wb_dat_i, wb_sel_i);
				`VPS_REG_PATH_SPEED: spd_q[plane_sel_q] <= merge(spd_q[plane_sel_q], wb_dat_i, wb_sel_i);
				`VPS_REG_PATH_ACCEL: acc_q[plane_sel_q] <= merge(acc_q[plane_sel_q], wb_dat_i, wb_sel_i);
				`VPS_REG_PATH_DECEL: dec_q[plane_sel_q] <= merge(dec_q[plane_sel_q], wb_dat_i, wb_sel_i);
				`VPS_REG_SPEED_RATIO: ratio_q[plane_sel_q] <= wb_dat_i[16:0];
				`VPS_REG_SCURVE: itc_q[plane_sel_q] <= wb_dat_i[8:0];
				`VPS_REG_AFTER_DIST: trip_q <= merge(trip_q, wb_dat_i, wb_sel_i);
				default: ;
			endcase
		end
	end

	// Queue bookkeeping
	always @(posedge clk_i) begin
		if (rst_i || clr_ok) begin
			owner_q <= 1'b0;
			end_seen_q <= 1'b0;
			total_q <= 32'h0;
			head0_q <= 16'h0000;
		end else begin
			if (push_ok) begin
				if (fifo_empty && !running) begin
					owner_q <= plane_sel_q;
					head0_q <= push_head;
					total_q <= slen_q;
				end else
					total_q <= total_q + slen_q;
			end
			if (cmd_wr && wb_dat_i[`VPS_CMD_END] && !(fifo_empty && !running))
				end_seen_q <= 1'b1;
			else if (seg_end && fifo_empty)
				end_seen_q <= 1'b0;
		end
	end

	// Servo tick divider keeps counting so profile steps stay evenly spaced
	always @(posedge clk_i) begin
		if (rst_i || tick)
			tick_cnt_q <= TICK_CYC[16:0] - 17'h00001;
		else
			tick_cnt_q <= tick_cnt_q - 17'h00001;
	end

	// Path engine
	always @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= ST_IDLE;
			run_sys_q <= 1'b0;
			dry_stop_q <= 1'b0;
			vert_a_q <= 32'h0;
			vert_b_q <= 32'h0;
			dist_done_q <= 32'h0;
			seg_cnt_q <= 10'h000;
			cur_arc_q <= 1'b0;
			cur_dx_q <= 32'h0;
			cur_dy_q <= 32'h0;
			cur_len_q <= 32'h0;
			cur_ang_q <= 32'h0;
			seg_pos_q <= 48'h0;
			v_fx_q <= 48'h0;
			a_eff_q <= 33'h0;
			frac_q <= 16'h0000;
			pos_a_o <= 32'h0;
			pos_b_o <= 32'h0;
			tangent_pos_o <= 32'h0;
		end else begin
			if (pop)
				{cur_arc_q, cur_dx_q, cur_dy_q, cur_len_q, cur_ang_q} <= fifo_dout;
			if (tangent_en_o)
				tangent_pos_o <= tan_of(toffs_q, tscale_q, head_now);
			case (st_q)
				ST_IDLE: begin
					if (beg_ok) begin
						st_q <= ST_RUN;
						run_sys_q <= cmd_sys;
						dry_stop_q <= 1'b0;
						vert_a_q <= pos_a_o;
						vert_b_q <= pos_b_o;
						dist_done_q <= 32'h0;
						seg_cnt_q <= 10'h000;
						seg_pos_q <= 48'h0;
						v_fx_q <= 48'h0;
						a_eff_q <= 33'h0;
						frac_q <= 16'h0000;
					end
				end
				ST_RUN: begin
					if (tick) begin
						// Smoothing shapes acceleration, so jerk is bounded
						a_eff_q <= a_eff_q + a_step[40:8];
						if ($signed(a_eff_q) < 0 && v_fx_q < {16'h0, -a_eff_q[31:0]})
							v_fx_q <= 48'h0;
						else
							v_fx_q <= v_fx_q + {{15{a_eff_q[32]}}, a_eff_q};
						if (decel && v_now < `VPS_VMIN)
							v_fx_q <= {6'h0, `VPS_VMIN, 10'h000};
						seg_pos_q <= seg_pos_q + {16'h0, v_now};
						st_q <= ST_CHK;
					end
				end
				ST_CHK: begin
					if (seg_end) begin
						vert_a_q <= vert_a_q + cur_dx_q;
						vert_b_q <= vert_b_q + cur_dy_q;
						dist_done_q <= dist_done_q + cur_len_q;
						frac_q <= 16'h0000;
						if (!fifo_empty) begin
							seg_pos_q <= seg_pos_q - len_fx;
							seg_cnt_q <= seg_cnt_q + 10'h001;
							st_q <= ST_RUN;
						end else begin
							// Without an end marker the stop is abrupt, no ramp
							dry_stop_q <= !end_seen_q;
							seg_pos_q <= 48'h0;
							v_fx_q <= 48'h0;
							pos_a_o <= vert_a_q + cur_dx_q;
							pos_b_o <= vert_b_q + cur_dy_q;
							st_q <= ST_IDLE;
						end
					end else
						st_q <= ST_DIV;
				end
				ST_DIV: begin
					if (div_done) begin
						frac_q <= div_frac;
						pos_a_o <= vert_a_q + frac_mul32(cur_dx_q, div_frac);
						pos_b_o <= vert_b_q + frac_mul32(cur_dy_q, div_frac);
						st_q <= ST_RUN;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end
endmodule

// [dv/vps_axis_model.sv]
// Purpose: Behavioural axis drives and encoders that track the command positions
// Assumes: Ideal encoders, one count resolution
// Notes: STEP limits counts per cycle; a small STEP models a sluggish drive
`timescale 1ns/10ps
module vps_axis_model #(
	parameter int STEP = 8
) (
	input wire clk_i,
	input wire rst_i,
	input wire [31:0] cmd_a_i,
	input wire [31:0] cmd_b_i,
	input wire [31:0] cmd_t_i,
	output logic [31:0] act_a_o,
	output logic [31:0] act_b_o,
	output logic [31:0] act_t_o
);
	function automatic logic [31:0] trk(input logic [31:0] act, input logic [31:0] cmd);
		int d;
		d = $signed(cmd) - $signed(act);
		if (d > STEP) d = STEP;
		if (d < -STEP) d = -STEP;
		return act + 32'(d);
	endfunction
	always @(posedge clk_i) begin
		if (rst_i) begin
			act_a_o <= 32'h0;
			act_b_o <= 32'h0;
			act_t_o <= 32'h0;
		end else begin
			act_a_o <= trk(act_a_o, cmd_a_i);
			act_b_o <= trk(act_b_o, cmd_b_i);
			act_t_o <= trk(act_t_o, cmd_t_i);
		end
	end
endmodule

// [dv/vps_path_seq_sva.sv]
// Purpose: Port-level checks of the path sequencer
// Assumes: One clock, synchronous active-high reset
// Notes: Stalled reads are judged at their acknowledge
`timescale 1ns/10ps
`include "vps_map.vh"
module vps_path_seq_sva #(
	parameter TICK_CYC = 200
) (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire [2:0] axis_m_o,
	input wire [2:0] axis_n_o,
	input wire [2:0] axis_p_o,
	input wire tangent_en_o,
	input wire [31:0] pos_a_o,
	input wire [31:0] pos_b_o,
	input wire [31:0] tangent_pos_o,
	input wire moving_o,
	input wire run_sys_o
);
	wire take_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire beg_w = take_w && wb_we_i && wb_adr_i == `VPS_REG_CMD && wb_dat_i[`VPS_CMD_BEGIN];
	reg rd_wait_q;
	reg rd_trip_q;
	reg beg_sys_q;
	reg [31:0] trip_q;
	reg [7:0] idle_q;
	always @(posedge clk_i) begin
		if (rst_i) begin
			rd_wait_q <= 1'b0;
			rd_trip_q <= 1'b0;
			beg_sys_q <= 1'b0;
			trip_q <= 32'h0;
			idle_q <= 8'h00;
		end else begin
			if (beg_w) beg_sys_q <= wb_dat_i[`VPS_CMD_SYS];
			if (take_w && wb_we_i && wb_adr_i == `VPS_REG_AFTER_DIST) trip_q <= wb_dat_i;
			if (take_w) rd_wait_q <= !wb_we_i && wb_adr_i == `VPS_REG_WAIT_DONE;
			if (take_w) rd_trip_q <= !wb_we_i && wb_adr_i == `VPS_REG_AFTER_DIST;
			idle_q <= moving_o ? 8'h00 : (idle_q == 8'hff ? idle_q : idle_q + 8'h01);
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	chk_write_ack: assert property (take_w && wb_we_i |=> wb_ack_o) else $error("write not acked next cycle");
	chk_ack_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
	chk_axes_write: assert property (
		$changed({tangent_en_o, axis_p_o, axis_n_o, axis_m_o}) |->
		$past(take_w && wb_we_i && wb_adr_i == `VPS_REG_PLANE_AXES)) else $error("axis codes changed unasked");
	chk_tangent_hold: assert property (
		!tangent_en_o && !$past(tangent_en_o) |-> $stable(tangent_pos_o)) else $error("tangent moved while off");
	chk_begin_cause: assert property (
		$rose(moving_o) |-> $past(beg_w) || $past(beg_w, 2) || $past(beg_w, 3)) else $error("run without begin");
	chk_run_system: assert property (
		$rose(moving_o) |-> ##[0:1] run_sys_o == beg_sys_q) else $error("wrong running system");
	chk_wait_done: assert property (
		wb_ack_o && rd_wait_q |-> !$past(moving_o) && wb_dat_o == 32'h0) else $error("wait released early");
	chk_trip_reach: assert property (
		wb_ack_o && rd_trip_q && $past(moving_o) |-> wb_dat_o >= trip_q) else $error("trip released early");
	chk_idle_still: assert property (
		idle_q > 8'h28 |-> $stable(pos_a_o) && $stable(pos_b_o)) else $error("axes move while idle");
	cover property ($rose(moving_o));
	cover property (wb_ack_o && rd_wait_q);
	cover property (wb_ack_o && rd_trip_q && $past(moving_o));
	cover property ($rose(tangent_en_o));
endmodule
bind vps_path_seq vps_path_seq_sva #(.TICK_CYC(TICK_CYC)) u_sva (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .axis_m_o(axis_m_o), .axis_n_o(axis_n_o),
	.axis_p_o(axis_p_o), .tangent_en_o(tangent_en_o), .pos_a_o(pos_a_o), .pos_b_o(pos_b_o),
	.tangent_pos_o(tangent_pos_o), .moving_o(moving_o), .run_sys_o(run_sys_o));

// [dv/vps_path_seq_tb_top.sv]
// Purpose: Self-checking bench of the path sequencer
// Assumes: Servo tick shortened to 200 cycles
// Notes: Each scenario task judges its own results
`timescale 1ns/10ps
`include "vps_map.vh"
module vps_path_seq_tb_top;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hf;
	logic [31:0] dat = 32'h0, rdat;
	wire [31:0] dat_o, pa, pb, pt, aa, ab, at;
	wire ack, ten, mov, rsys;
	wire [2:0] am, an, ap;
	int n_mismatch = 0, n_checks = 0;
	vps_path_seq #(.TICK_CYC(200)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.axis_m_o(am), .axis_n_o(an), .axis_p_o(ap), .tangent_en_o(ten), .pos_a_o(pa), .pos_b_o(pb),
		.tangent_pos_o(pt), .moving_o(mov), .run_sys_o(rsys));
	vps_axis_model u_axes (.clk_i(clk_i), .rst_i(rst_i), .cmd_a_i(pa), .cmd_b_i(pb), .cmd_t_i(pt),
		.act_a_o(aa), .act_b_o(ab), .act_t_o(at));
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Holds the request until ack is sampled high; trip and wait reads may stall long
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 30000);
		if (n >= 30000) begin
			n_mismatch++;
			conclude;
		end
		rdat = dat_o;
		cyc <= 0;
		stb <= 0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1, a, d);
	endtask
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
		xfer(0, a, 32'h0);
		chk(nm, e, rdat);
	endtask
	task automatic push(input logic [31:0] dx, dy, len, ang, input logic arc);
		wr(`VPS_REG_SEG_DX, dx);
		wr(`VPS_REG_SEG_DY, dy);
		wr(`VPS_REG_SEG_LEN, len);
		wr(`VPS_REG_SEG_ANGLE, ang);
		wr(`VPS_REG_CMD, {22'h0, arc, 9'h008});
	endtask
	task automatic t_reset;
		rd_chk("speed", `VPS_REG_PATH_SPEED, `VPS_RST_SPEED);
		rd_chk("decel", `VPS_REG_PATH_DECEL, `VPS_RST_ACCEL);
		rd_chk("ratio", `VPS_REG_SPEED_RATIO, 32'h00002710);
		rd_chk("scurve", `VPS_REG_SCURVE, 32'h00000100);
		rd_chk("free", `VPS_REG_FREE_SLOTS, 32'h000001ff);
		rd_chk("unmapped", 8'h24, 32'h0);
		wr(`VPS_REG_PATH_ACCEL, 32'h00400000);
		wr(`VPS_REG_PATH_DECEL, 32'h00400000);
		rd_chk("accel", `VPS_REG_PATH_ACCEL, 32'h00400000);
	endtask
	task automatic t_fill;
		push(32'h2, 32'h0, 32'h2, 32'h0, 0);
		repeat (510) wr(`VPS_REG_CMD, 32'h008);
		rd_chk("free_full", `VPS_REG_FREE_SLOTS, 32'h0);
		wr(`VPS_REG_CMD, 32'h008);
		rd_chk("free_over", `VPS_REG_FREE_SLOTS, 32'h0);
		rd_chk("len_full", `VPS_REG_LEN_TOTAL, 32'h000003fe);
		wr(`VPS_REG_CMD, 32'h102);
		rd_chk("clr_other", `VPS_REG_FREE_SLOTS, 32'h0);
		wr(`VPS_REG_CMD, 32'h002);
		rd_chk("clr_own", `VPS_REG_FREE_SLOTS, 32'h000001ff);
	endtask
	task automatic t_tangent;
		wr(`VPS_REG_PLANE_AXES, 32'h00000a10);
		@(negedge clk_i);
		chk("axes", 32'h00000a10, {20'h0, ten, ap, 1'b0, an, 1'b0, am});
		wr(`VPS_REG_TAN_SCALE, 32'h00010000);
		wr(`VPS_REG_TAN_OFFSET, 32'h00000064);
		push(32'h190, 32'h0, 32'h190, 32'h0, 0);
		push(32'h0, 32'h12c, 32'h12c, {16'h0, `VPS_ANG_QUARTER}, 0);
		wr(`VPS_REG_CMD, 32'h004);
		rd_chk("tan_init", `VPS_REG_TAN_INIT, 32'h00000064);
		rd_chk("len_total", `VPS_REG_LEN_TOTAL, 32'h000002bc);
	endtask
	task automatic t_run;
		wr(`VPS_REG_CMD, 32'h001);
		@(negedge clk_i);
		chk("run_s", 32'h2, {30'h0, mov, rsys});
		rd_chk("seg0", `VPS_REG_SEG_COUNT, 32'h0);
		rd_chk("vtx_a0", `VPS_REG_VERTEX_A, 32'h0);
		wr(`VPS_REG_AFTER_DIST, 32'h000000c8);
		xfer(0, `VPS_REG_AFTER_DIST, 32'h0);
		chk("trip200", 32'h1, {31'h0, rdat >= 32'hc8 && rdat < 32'h190});
		@(negedge clk_i);
		chk("tan_seg0", 32'h00000064, pt);
		wr(`VPS_REG_AFTER_DIST, 32'h000001f4);
		xfer(0, `VPS_REG_AFTER_DIST, 32'h0);
		chk("trip500", 32'h1, {31'h0, rdat >= 32'h1f4 && rdat < 32'h2bc});
		rd_chk("seg1", `VPS_REG_SEG_COUNT, 32'h1);
		rd_chk("vtx_a1", `VPS_REG_VERTEX_A, 32'h190);
		rd_chk("vtx_b1", `VPS_REG_VERTEX_B, 32'h0);
		@(negedge clk_i);
		chk("tan_seg1", 32'h000000be, pt);
		rd_chk("wait", `VPS_REG_WAIT_DONE, 32'h0);
		@(negedge clk_i);
		chk("stopped", 32'h0, {31'h0, mov});
		chk("end_a", 32'h190, pa);
		chk("end_b", 32'h12c, pb);
		repeat (20) @(posedge clk_i);
		chk("drive_a", 32'h190, aa);
	endtask
	task automatic t_sys_t;
		wr(`VPS_REG_PLANE_AXES, 32'h00000210);
		@(negedge clk_i);
		chk("tan_off", 32'h0, {31'h0, ten});
		wr(`VPS_REG_PLANE_SELECT, 32'h1);
		rd_chk("accel_t", `VPS_REG_PATH_ACCEL, `VPS_RST_ACCEL);
		wr(`VPS_REG_SCURVE, 32'h00000080);
		rd_chk("scurve_t", `VPS_REG_SCURVE, 32'h00000080);
		push(32'hffffff9c, 32'h64, 32'h9d, {`VPS_ANG_QUARTER, 16'h0}, 1);
		wr(`VPS_REG_CMD, 32'h001);
		@(negedge clk_i);
		chk("beg_other", 32'h0, {31'h0, mov});
		wr(`VPS_REG_CMD, 32'h101);
		@(negedge clk_i);
		chk("run_t", 32'h3, {30'h0, mov, rsys});
		rd_chk("wait_t", `VPS_REG_WAIT_DONE, 32'h0);
		xfer(0, `VPS_REG_CMD, 32'h0);
		chk("dry_stop", 32'h1, {31'h0, rdat[4]});
		chk("arc_a", 32'h12c, pa);
		chk("arc_b", 32'h190, pb);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 0;
		t_reset;
		t_fill;
		t_tangent;
		t_run;
		t_sys_t;
		conclude;
	end
	// About six times the expected run length
	initial begin
		repeat (100000) @(posedge clk_i);
		n_mismatch++;
		conclude;
	end
endmodule
